// *** src/rail_defines.svh ***
/*
 * Shared constants of the rail supervisor: clock rate, filter times,
 * register offsets, reset values and regulator identities.
 * Assumes a 125 MHz hclk and byte addresses on a 32-bit AHB-Lite bus.
 */
`ifndef RAIL_DEFINES_SVH
`define RAIL_DEFINES_SVH

// clock rate and filter times in microseconds
`define RAIL_CLK_MHZ 125
`define RAIL_OV_SHORT_US 25
`define RAIL_OV_LONG_US 45
`define RAIL_UV_T0_US 5
`define RAIL_UV_T1_US 15
`define RAIL_UV_T2_US 25
`define RAIL_UV_T3_US 40
`define RAIL_CNT_W 13
`define RAIL_OV_SHORT_CYC 13'(`RAIL_OV_SHORT_US * `RAIL_CLK_MHZ)
`define RAIL_UV_T0_CYC 13'(`RAIL_UV_T0_US * `RAIL_CLK_MHZ)
`define RAIL_UV_T1_CYC 13'(`RAIL_UV_T1_US * `RAIL_CLK_MHZ)
`define RAIL_UV_T2_CYC 13'(`RAIL_UV_T2_US * `RAIL_CLK_MHZ)

// threshold in tenths of a percent: base plus step per fuse code
`define RAIL_TH_BASE 7'h19
`define RAIL_TH_STEP 7'h05

// register byte offsets
`define RAIL_ADDR_REACT_A 8'h00
`define RAIL_ADDR_REACT_B 8'h04
`define RAIL_ADDR_SCALING 8'h08
`define RAIL_ADDR_FLAGS 8'h0C
`define RAIL_ADDR_AUX_SEL0 8'h10
`define RAIL_ADDR_AUX_SEL1 8'h14
`define RAIL_ADDR_AUX_SEL2 8'h18
`define RAIL_ADDR_AUX_SEL3 8'h1C

// reset values: over fields 10, under fields 01
`define RAIL_REACT_A_RST 12'h666
`define RAIL_REACT_B_RST 4'h6
`define RAIL_AUX_SEL_RST 16'hFFFF

// field positions
`define RAIL_SCL_CODE_LSB 0
`define RAIL_SCL_CMPL_LSB 8
`define RAIL_SCL_SIGN_BIT 16
`define RAIL_SCL_REJ_BIT 24
`define RAIL_FLAG_UV_LSB 8

// regulator identities
`define RAIL_REG_ID_CORE 4'h4
`define RAIL_REG_ID_HV 4'h8
`define RAIL_REG_ID_EXT 4'hF
`define RAIL_IO_FUSE_EXT 3'h7

`endif

// *** src/rail_pkg.sv ***
/*
 * Types of the rail supervisor: state structs of every module.
 * Assumes rail_defines.svh for widths that these types mirror.
 */
package rail_pkg;

	typedef logic [1:0] reaction_t;
	typedef logic [3:0] reg_id_t;

	typedef struct packed {
		logic [12:0] over_cnt;
		logic [12:0] under_cnt;
		logic over_fault;
		logic under_fault;
		logic over_rise;
		logic under_rise;
	} filter_state_t;

	typedef struct packed {
		logic [5:0] code;
		logic raise;
		logic rejected;
		logic accepted;
	} scaling_state_t;

	typedef struct packed {
		logic [11:0] react_a;
		logic [3:0] react_b;
		logic [15:0] aux_sel;
		logic [6:0] ov_flag;
		logic [6:0] uv_flag;
		logic wr_pend;
		logic rd_pend;
		logic [7:0] addr;
		logic [31:0] rdata;
		logic ready;
		logic fs_n;
		logic rst_n;
		logic cnt_pulse;
		logic [8:0] reg_off;
		logic [6:0] core_ov_th;
		logic [6:0] core_uv_th;
		logic [6:0] io_ov_th;
		logic [6:0] io_uv_th;
		logic [6:0] hv_ov_th;
		logic [6:0] hv_uv_th;
		logic io_3v3;
		logic hv_dac;
		logic hv_3v3;
	} top_state_t;

endpackage

// *** src/rail_filter_if.sv ***
/*
 * Link between the supervisor and one fault filter.
 * Assumes both ends run on hclk.
 */
interface rail_filter_if;
	logic enable;
	logic over_raw;
	logic under_raw;
	logic over_sel;
	logic [1:0] under_sel;
	logic over_fault;
	logic under_fault;
	logic over_rise;
	logic under_rise;

	modport filter (
		input enable, over_raw, under_raw, over_sel, under_sel,
		output over_fault, under_fault, over_rise, under_rise
	);
	modport monitor (
		output enable, over_raw, under_raw, over_sel, under_sel,
		input over_fault, under_fault, over_rise, under_rise
	);
endinterface

// *** src/rail_fault_filter.sv ***
/*
 * Persistence filter for one monitor: over and under comparator
 * levels must stand for the selected time before a fault is declared.
 * Assumes comparator levels synchronous to hclk.
 */
`include "rail_defines.svh"

module rail_fault_filter #(
	parameter int unsigned OV_LONG_CYCLES = 5625,
	parameter int unsigned UV_LONGEST_CYCLES = 5000
) (
	// clock and reset
	input logic hclk,
	input logic hresetn,
	// monitor side
	rail_filter_if.filter mon
);

	localparam logic [12:0] OV_LONG_C = 13'(OV_LONG_CYCLES);
	localparam logic [12:0] UV_LONG_C = 13'(UV_LONGEST_CYCLES);

	rail_pkg::filter_state_t s_q;
	rail_pkg::filter_state_t s_d;
	logic [12:0] ov_limit;
	logic [12:0] uv_limit;

	always_comb begin
		s_d = s_q;
		s_d.over_rise = 1'b0;
		s_d.under_rise = 1'b0;
		ov_limit = mon.over_sel ? OV_LONG_C : `RAIL_OV_SHORT_CYC;
		unique case (mon.under_sel)
			2'h0: uv_limit = `RAIL_UV_T0_CYC;
			2'h1: uv_limit = `RAIL_UV_T1_CYC;
			2'h2: uv_limit = `RAIL_UV_T2_CYC;
			2'h3: uv_limit = UV_LONG_C;
		endcase
		// disabled monitor holds everything clear
		if (!mon.enable || !mon.over_raw) begin
			s_d.over_cnt = '0;
			s_d.over_fault = 1'b0;
		end else if (!s_q.over_fault) begin
			if (s_q.over_cnt == ov_limit - 13'h0001) begin
				s_d.over_fault = 1'b1;
				s_d.over_rise = 1'b1;
			end else begin
				s_d.over_cnt = s_q.over_cnt + 13'h0001;
			end
		end
		if (!mon.enable || !mon.under_raw) begin
			s_d.under_cnt = '0;
			s_d.under_fault = 1'b0;
		end else if (!s_q.under_fault) begin
			if (s_q.under_cnt == uv_limit - 13'h0001) begin
				s_d.under_fault = 1'b1;
				s_d.under_rise = 1'b1;
			end else begin
				s_d.under_cnt = s_q.under_cnt + 13'h0001;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign mon.over_fault = s_q.over_fault;
	assign mon.under_fault = s_q.under_fault;
	assign mon.over_rise = s_q.over_rise;
	assign mon.under_rise = s_q.under_rise;

endmodule

// *** src/rail_scaling_check.sv ***
/*
 * Static voltage scaling command check: complement test, clamp to
 * the fused step limit and sign restriction.
 * Assumes the write strobe is already gated to the init phase.
 */
`include "rail_defines.svh"

module rail_scaling_check (
	// clock and reset
	input logic hclk,
	input logic hresetn,
	// command
	input logic cmd_valid,
	input logic [5:0] cmd_code,
	input logic [5:0] cmd_complement,
	input logic cmd_raise,
	// fuses
	input logic [5:0] step_limit_fuse,
	input logic bidirectional_fuse,
	// result
	output logic [5:0] applied_code,
	output logic applied_raise,
	output logic rejected,
	output logic accepted
);

	rail_pkg::scaling_state_t s_q;
	rail_pkg::scaling_state_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.accepted = 1'b0;
		if (cmd_valid) begin
			if (cmd_complement == ~cmd_code) begin
				// thermometer limit is also the highest code
				s_d.code = (cmd_code > step_limit_fuse) ?
					step_limit_fuse : cmd_code;
				s_d.raise = bidirectional_fuse & cmd_raise;
				s_d.rejected = 1'b0;
				s_d.accepted = 1'b1;
			end else begin
				s_d.rejected = 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign applied_code = s_q.code;
	assign applied_raise = s_q.raise;
	assign rejected = s_q.rejected;
	assign accepted = s_q.accepted;

endmodule

// *** src/rail_monitor_svs_safety_reaction.sv ***
/*
 * Rail supervisor: fault filters of core, IO, high-voltage linear and
 * four auxiliary monitors, reaction on the fail-safe and reset outputs,
 * regulator shutdown on overvoltage and static voltage scaling.
 * Assumes a single AHB-Lite master and comparators synchronous to hclk.
 */
`include "rail_defines.svh"

module rail_monitor_svs_safety_reaction #(
	parameter int unsigned OV_LONG_CYCLES =
		`RAIL_OV_LONG_US * `RAIL_CLK_MHZ,
	parameter int unsigned UV_LONGEST_CYCLES =
		`RAIL_UV_T3_US * `RAIL_CLK_MHZ
) (
	// clock and reset
	input logic hclk,
	input logic hresetn,
	// ahb-lite slave
	input logic hsel,
	input logic [31:0] haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic [2:0] hsize,
	input logic [31:0] hwdata,
	input logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// fail-safe state machine
	input logic safety_init_phase,
	input logic safety_monitor_enable,
	// comparators: 0 core, 1 io, 2 hv linear, 3..6 aux
	input logic [6:0] over_raw,
	input logic [6:0] under_raw,
	// core fuses
	input logic [3:0] core_over_threshold_fuse,
	input logic [3:0] core_under_threshold_fuse,
	input logic core_over_filter_fuse,
	input logic [1:0] core_under_filter_fuse,
	// io fuses
	input logic [3:0] io_over_threshold_fuse,
	input logic [3:0] io_under_threshold_fuse,
	input logic io_over_filter_fuse,
	input logic [1:0] io_under_filter_fuse,
	input logic [2:0] io_source_select_fuse,
	input logic io_nominal_level_fuse,
	// hv linear fuses
	input logic [3:0] hv_linear_over_threshold_fuse,
	input logic [3:0] hv_linear_under_threshold_fuse,
	input logic hv_linear_over_filter_fuse,
	input logic [1:0] hv_linear_under_filter_fuse,
	input logic hv_linear_mode_fuse,
	input logic hv_linear_level_fuse,
	// aux filter fuses, one per input
	input logic [3:0] aux_over_filter_fuse,
	input logic [7:0] aux_under_filter_fuse,
	// scaling fuses
	input logic [5:0] scaling_step_limit_fuse,
	input logic scaling_bidirectional_fuse,
	// safety outputs
	output logic failsafe_output_n,
	output logic reset_output_n,
	output logic fault_count_pulse,
	// regulator shutdown, index = regulator id, 8 = hv linear
	output logic [8:0] regulator_off,
	// thresholds in tenths of a percent
	output logic [6:0] core_over_threshold,
	output logic [6:0] core_under_threshold,
	output logic [6:0] io_over_threshold,
	output logic [6:0] io_under_threshold,
	output logic [6:0] hv_linear_over_threshold,
	output logic [6:0] hv_linear_under_threshold,
	// references
	output logic io_ref_3v3,
	output logic hv_linear_ref_tracks_dac,
	output logic hv_linear_ref_3v3,
	// static voltage scaling, shared by converter and core monitor
	output logic [5:0] scaling_offset_code,
	output logic scaling_offset_polarity,
	output logic scaling_rejected
);

	rail_pkg::top_state_t s_q;
	rail_pkg::top_state_t s_d;

	rail_filter_if fif [7] ();

	logic [6:0] ov_fault;
	logic [6:0] uv_fault;
	logic [6:0] ov_rise;
	logic [6:0] uv_rise;
	logic [6:0] ov_sel;
	logic [13:0] uv_sel;
	logic scaling_wr;
	logic scaling_accepted;
	logic take;

	assign ov_sel = {aux_over_filter_fuse, hv_linear_over_filter_fuse,
		io_over_filter_fuse, core_over_filter_fuse};
	assign uv_sel = {aux_under_filter_fuse, hv_linear_under_filter_fuse,
		io_under_filter_fuse, core_under_filter_fuse};

	// one filter per monitor
	genvar g;
	generate
		for (g = 0; g < 7; g++) begin : g_mon
			assign fif[g].enable = safety_monitor_enable;
			assign fif[g].over_raw = over_raw[g];
			assign fif[g].under_raw = under_raw[g];
			assign fif[g].over_sel = ov_sel[g];
			assign fif[g].under_sel = uv_sel[2 * g +: 2];
			assign ov_fault[g] = fif[g].over_fault;
			assign uv_fault[g] = fif[g].under_fault;
			assign ov_rise[g] = fif[g].over_rise;
			assign uv_rise[g] = fif[g].under_rise;
			rail_fault_filter #(
				.OV_LONG_CYCLES(OV_LONG_CYCLES),
				.UV_LONGEST_CYCLES(UV_LONGEST_CYCLES)
			) u_filter (
				.hclk(hclk),
				.hresetn(hresetn),
				.mon(fif[g])
			);
		end
	endgenerate

	// scaling writes only count during the init phase
	assign scaling_wr = s_q.wr_pend && safety_init_phase &&
		(s_q.addr == `RAIL_ADDR_SCALING);

	rail_scaling_check u_scaling (
		.hclk(hclk),
		.hresetn(hresetn),
		.cmd_valid(scaling_wr),
		.cmd_code(hwdata[`RAIL_SCL_CODE_LSB +: 6]),
		.cmd_complement(hwdata[`RAIL_SCL_CMPL_LSB +: 6]),
		.cmd_raise(hwdata[`RAIL_SCL_SIGN_BIT]),
		.step_limit_fuse(scaling_step_limit_fuse),
		.bidirectional_fuse(scaling_bidirectional_fuse),
		.applied_code(scaling_offset_code),
		.applied_raise(scaling_offset_polarity),
		.rejected(scaling_rejected),
		.accepted(scaling_accepted)
	);

	assign take = hsel && hready && htrans[1];

	always_comb begin
		rail_pkg::reaction_t ov_react;
		rail_pkg::reaction_t uv_react;
		rail_pkg::reg_id_t src_id;
		logic fs_req;
		logic rst_req;
		logic cnt_req;
		logic [13:0] flag_clr;
		ov_react = '0;
		uv_react = '0;
		src_id = '0;
		fs_req = 1'b0;
		rst_req = 1'b0;
		cnt_req = 1'b0;
		flag_clr = '0;
		s_d = s_q;

		// address phase; reads take one wait state
		s_d.wr_pend = take && hwrite;
		s_d.rd_pend = take && !hwrite;
		s_d.ready = !(take && !hwrite);
		if (take) begin
			s_d.addr = {haddr[7:2], 2'b00};
		end

		// write data phase
		if (s_q.wr_pend) begin
			unique case (s_q.addr)
				`RAIL_ADDR_REACT_A: begin
					if (safety_init_phase) begin
						s_d.react_a = hwdata[11:0];
					end
				end
				`RAIL_ADDR_REACT_B: begin
					if (safety_init_phase) begin
						s_d.react_b = hwdata[3:0];
					end
				end
				`RAIL_ADDR_FLAGS: begin
					flag_clr = {hwdata[`RAIL_FLAG_UV_LSB +: 7], hwdata[6:0]};
				end
				`RAIL_ADDR_AUX_SEL0: s_d.aux_sel[3:0] = hwdata[3:0];
				`RAIL_ADDR_AUX_SEL1: s_d.aux_sel[7:4] = hwdata[3:0];
				`RAIL_ADDR_AUX_SEL2: s_d.aux_sel[11:8] = hwdata[3:0];
				`RAIL_ADDR_AUX_SEL3: s_d.aux_sel[15:12] = hwdata[3:0];
				default: begin
				end
			endcase
		end

		// read data phase, after any write of the cycle before
		if (s_q.rd_pend) begin
			s_d.rdata = '0;
			unique case (s_q.addr)
				`RAIL_ADDR_REACT_A: s_d.rdata[11:0] = s_q.react_a;
				`RAIL_ADDR_REACT_B: s_d.rdata[3:0] = s_q.react_b;
				`RAIL_ADDR_SCALING: begin
					s_d.rdata[`RAIL_SCL_CODE_LSB +: 6] = scaling_offset_code;
					s_d.rdata[`RAIL_SCL_CMPL_LSB +: 6] = ~scaling_offset_code;
					s_d.rdata[`RAIL_SCL_SIGN_BIT] = scaling_offset_polarity;
					s_d.rdata[`RAIL_SCL_REJ_BIT] = scaling_rejected;
				end
				`RAIL_ADDR_FLAGS: begin
					s_d.rdata[6:0] = s_q.ov_flag;
					s_d.rdata[`RAIL_FLAG_UV_LSB +: 7] = s_q.uv_flag;
				end
				`RAIL_ADDR_AUX_SEL0: s_d.rdata[3:0] = s_q.aux_sel[3:0];
				`RAIL_ADDR_AUX_SEL1: s_d.rdata[3:0] = s_q.aux_sel[7:4];
				`RAIL_ADDR_AUX_SEL2: s_d.rdata[3:0] = s_q.aux_sel[11:8];
				`RAIL_ADDR_AUX_SEL3: s_d.rdata[3:0] = s_q.aux_sel[15:12];
				default: s_d.rdata = '0;
			endcase
		end

		// sticky flags; a new fault wins over a clear in the same cycle
		s_d.ov_flag = (s_q.ov_flag & ~flag_clr[6:0]) | ov_rise;
		s_d.uv_flag = (s_q.uv_flag & ~flag_clr[13:7]) | uv_rise;

		// reaction per monitor; aux inputs share one field pair
		s_d.reg_off = '0;
		for (int m = 0; m < 7; m++) begin
			if (m < 3) begin
				ov_react = s_q.react_a[4 * m +: 2];
				uv_react = s_q.react_a[4 * m + 2 +: 2];
			end else begin
				ov_react = s_q.react_b[1:0];
				uv_react = s_q.react_b[3:2];
			end
			// decode: 00 none, 01 failsafe, 1x failsafe and reset
			fs_req = fs_req | (s_q.ov_flag[m] && ov_react != 2'b00);
			fs_req = fs_req | (s_q.uv_flag[m] && uv_react != 2'b00);
			rst_req = rst_req | (s_q.ov_flag[m] && ov_react[1]);
			rst_req = rst_req | (s_q.uv_flag[m] && uv_react[1]);
			// a no-action fault leaves the error counter alone
			cnt_req = cnt_req | (ov_rise[m] && ov_react != 2'b00);
			cnt_req = cnt_req | (uv_rise[m] && uv_react != 2'b00);

			if (m == 0) begin
				src_id = `RAIL_REG_ID_CORE;
			end else if (m == 1) begin
				src_id = (io_source_select_fuse == `RAIL_IO_FUSE_EXT) ?
					`RAIL_REG_ID_EXT : {1'b0, io_source_select_fuse};
			end else if (m == 2) begin
				src_id = `RAIL_REG_ID_HV;
			end else begin
				src_id = s_q.aux_sel[4 * (m - 3) +: 4];
			end
			// level, so the regulator stays off while the fault stands
			for (int r = 0; r < 9; r++) begin
				// external id never matches: flag only
				if (ov_fault[m] && src_id == 4'(r)) begin
					s_d.reg_off[r] = 1'b1;
				end
			end
		end
		// fail-safe and reset outputs held while the flag stands
		s_d.fs_n = !fs_req;
		s_d.rst_n = !rst_req;
		s_d.cnt_pulse = cnt_req;

		// thresholds straight from the fuses
		s_d.core_ov_th = `RAIL_TH_BASE +
			7'(`RAIL_TH_STEP * core_over_threshold_fuse);
		s_d.core_uv_th = `RAIL_TH_BASE +
			7'(`RAIL_TH_STEP * core_under_threshold_fuse);
		s_d.io_ov_th = `RAIL_TH_BASE +
			7'(`RAIL_TH_STEP * io_over_threshold_fuse);
		s_d.io_uv_th = `RAIL_TH_BASE +
			7'(`RAIL_TH_STEP * io_under_threshold_fuse);
		s_d.hv_ov_th = `RAIL_TH_BASE +
			7'(`RAIL_TH_STEP * hv_linear_over_threshold_fuse);
		s_d.hv_uv_th = `RAIL_TH_BASE +
			7'(`RAIL_TH_STEP * hv_linear_under_threshold_fuse);

		s_d.io_3v3 = io_nominal_level_fuse;
		// switch mode tracks the converter dac, fixed at 0.8 V
		s_d.hv_dac = !hv_linear_mode_fuse;
		s_d.hv_3v3 = hv_linear_mode_fuse && hv_linear_level_fuse;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '{
				react_a: `RAIL_REACT_A_RST,
				react_b: `RAIL_REACT_B_RST,
				aux_sel: `RAIL_AUX_SEL_RST,
				ready: 1'b1,
				fs_n: 1'b1,
				rst_n: 1'b1,
				default: '0
			};
		end else begin
			s_q <= s_d;
		end
	end

	assign hrdata = s_q.rdata;
	assign hreadyout = s_q.ready;
	assign hresp = 1'b0;
	assign failsafe_output_n = s_q.fs_n;
	assign reset_output_n = s_q.rst_n;
	assign fault_count_pulse = s_q.cnt_pulse;
	assign regulator_off = s_q.reg_off;
	assign core_over_threshold = s_q.core_ov_th;
	assign core_under_threshold = s_q.core_uv_th;
	assign io_over_threshold = s_q.io_ov_th;
	assign io_under_threshold = s_q.io_uv_th;
	assign hv_linear_over_threshold = s_q.hv_ov_th;
	assign hv_linear_under_threshold = s_q.hv_uv_th;
	assign io_ref_3v3 = s_q.io_3v3;
	assign hv_linear_ref_tracks_dac = s_q.hv_dac;
	assign hv_linear_ref_3v3 = s_q.hv_3v3;

endmodule

// *** testbench/rail_asserts.sv ***
/*
 * Concurrent checks on the rail supervisor top ports.
 * Assumes static fuses and the bench bus master of the testbench.
 */
module rail_asserts #(
	parameter int unsigned OV_LONG_CYCLES = 40,
	parameter int unsigned UV_LONGEST_CYCLES = 30
) (
	// clock and reset
	input logic hclk,
	input logic hresetn,
	// bus
	input logic hsel,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic hready,
	input logic hreadyout,
	// monitors and fuses
	input logic safety_monitor_enable,
	input logic [6:0] over_raw,
	input logic [3:0] core_over_threshold_fuse,
	input logic [3:0] core_under_threshold_fuse,
	input logic io_nominal_level_fuse,
	input logic hv_linear_mode_fuse,
	input logic hv_linear_level_fuse,
	input logic [5:0] scaling_step_limit_fuse,
	input logic scaling_bidirectional_fuse,
	// outputs
	input logic failsafe_output_n,
	input logic reset_output_n,
	input logic fault_count_pulse,
	input logic [8:0] regulator_off,
	input logic [6:0] core_over_threshold,
	input logic [6:0] core_under_threshold,
	input logic io_ref_3v3,
	input logic hv_linear_ref_tracks_dac,
	input logic hv_linear_ref_3v3,
	input logic [5:0] scaling_offset_code,
	input logic scaling_offset_polarity,
	input logic scaling_rejected
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_core_ovth: assert property ($past(hresetn) |-> core_over_threshold ==
		7'h19 + 7'h05 * {3'h0, $past(core_over_threshold_fuse)})
		else $error("core over threshold wrong");
	a_core_uvth: assert property ($past(hresetn) |-> core_under_threshold ==
		7'h19 + 7'h05 * {3'h0, $past(core_under_threshold_fuse)})
		else $error("core under threshold wrong");
	a_io_ref: assert property ($past(hresetn) |->
		io_ref_3v3 == $past(io_nominal_level_fuse))
		else $error("io reference wrong");
	a_hv_ref: assert property ($past(hresetn) |->
		hv_linear_ref_tracks_dac == !$past(hv_linear_mode_fuse) &&
		hv_linear_ref_3v3 == $past(hv_linear_mode_fuse & hv_linear_level_fuse))
		else $error("hv linear reference wrong");
	a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite
		|=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_rst_with_fs: assert property (!reset_output_n |-> !failsafe_output_n)
		else $error("reset without failsafe");
	a_rej_keeps: assert property ($rose(scaling_rejected) |->
		$stable(scaling_offset_code))
		else $error("rejected offset applied");
	a_clamp_code: assert property (scaling_offset_code <=
		scaling_step_limit_fuse)
		else $error("offset above clamp");
	a_raise_gate: assert property ($rose(scaling_offset_polarity) |->
		scaling_bidirectional_fuse)
		else $error("raise without fuse");
	a_quiet_off: assert property (!safety_monitor_enable [*4] |->
		!fault_count_pulse)
		else $error("fault while disabled");
	a_off_cause: assert property ($rose(regulator_off[4]) |->
		$past(over_raw[0]))
		else $error("core shutdown without over");
endmodule

bind rail_monitor_svs_safety_reaction rail_asserts #(
	.OV_LONG_CYCLES(OV_LONG_CYCLES),
	.UV_LONGEST_CYCLES(UV_LONGEST_CYCLES)
) u_chk (.*);

// *** testbench/rail_far_side.sv ***
/*
 * Behavioural rails: comparator levels from bench fault requests.
 * Assumes core on regulator 4, hv linear on 8, io on its fuse id.
 */
module rail_far_side (
	// clock
	input logic hclk,
	// fault requests from the bench
	input logic [6:0] ov_req,
	input logic [6:0] uv_req,
	// regulator control
	input logic [8:0] regulator_off,
	input logic [2:0] io_source_select_fuse,
	// comparator levels
	output logic [6:0] over_raw,
	output logic [6:0] under_raw
);
	logic [2:0] dead = 3'h0;
	logic [2:0] off;
	// external io supply has no switch, so it never collapses
	assign off = {regulator_off[8], io_source_select_fuse != 3'h7 &&
		regulator_off[io_source_select_fuse], regulator_off[4]};
	initial over_raw = 7'h00;
	initial under_raw = 7'h00;
	// a switched-off rail stays down until the fault source goes away
	always @(posedge hclk) begin
		dead <= (dead | off) & ov_req[2:0];
		over_raw <= {ov_req[6:3], ov_req[2:0] & ~(dead | off)};
		under_raw <= uv_req;
	end
endmodule

// *** testbench/rail_monitor_svs_safety_reaction_tb.sv ***
/*
 * Self-checking bench of the rail supervisor.
 * Assumes the AHB-Lite slave is the only one on the bus.
 */
module rail_monitor_svs_safety_reaction_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int OV = 40;
	localparam int UV = 30;
	logic hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, hready;
	logic [31:0] haddr = 0, hwdata = 0, hrdata;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, safety_init_phase = 1, safety_monitor_enable = 0;
	logic [6:0] over_raw, under_raw, ov_req = 0, uv_req = 0;
	logic [3:0] core_over_threshold_fuse = 0, core_under_threshold_fuse = 0;
	logic [3:0] io_over_threshold_fuse = 0, io_under_threshold_fuse = 0;
	logic [3:0] hv_linear_over_threshold_fuse = 0;
	logic [3:0] hv_linear_under_threshold_fuse = 0, aux_over_filter_fuse = 0;
	logic core_over_filter_fuse = 1, io_over_filter_fuse = 1;
	logic hv_linear_over_filter_fuse = 1, io_nominal_level_fuse = 0;
	logic hv_linear_mode_fuse = 0, hv_linear_level_fuse = 0;
	logic scaling_bidirectional_fuse = 0;
	logic [1:0] core_under_filter_fuse = 2'h3, io_under_filter_fuse = 2'h3;
	logic [1:0] hv_linear_under_filter_fuse = 2'h0;
	logic [2:0] io_source_select_fuse = 3'h7;
	logic [7:0] aux_under_filter_fuse = 0;
	logic [5:0] scaling_step_limit_fuse = 6'h07, scaling_offset_code;
	logic failsafe_output_n, reset_output_n, fault_count_pulse;
	logic [8:0] regulator_off;
	logic [6:0] core_over_threshold, core_under_threshold, io_over_threshold;
	logic [6:0] io_under_threshold, hv_linear_over_threshold;
	logic [6:0] hv_linear_under_threshold;
	logic io_ref_3v3, hv_linear_ref_tracks_dac, hv_linear_ref_3v3;
	logic scaling_offset_polarity, scaling_rejected, seen;
	logic [31:0] q;
	int n_mismatch = 0, checks = 0;
	int pulses = 0;
	assign hready = hreadyout;
	always #4 hclk = ~hclk;
	// counts high cycles, so a stretched pulse shows up as extra counts
	always @(posedge hclk) begin
		if (fault_count_pulse === 1'b1) begin
			pulses <= pulses + 1;
		end
	end

	rail_monitor_svs_safety_reaction #(
		.OV_LONG_CYCLES(OV),
		.UV_LONGEST_CYCLES(UV)
	) dut (.*);
	rail_far_side model (.*);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask
	// single word transfer; waits as long as the slave stretches
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	function automatic logic [31:0] svw(logic [5:0] c, logic [5:0] n, logic s);
		return {15'h0, s, 2'h0, n, 2'h0, c};
	endfunction
	task automatic print_verdict;
		if (n_mismatch == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic t_regs;
		logic [7:0] a[6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h1C, 8'h20};
		logic [31:0] e[6] = '{32'h666, 32'h6, 32'h3F00, 32'hF, 32'hF, 32'h0};
		ahb(1, 8'h20, 32'hFFFFFFFF);
		foreach (a[i]) begin
			ahb(0, a[i], 32'h0);
			chk(q, e[i]);
		end
	endtask
	// bad complement, full-scale step clamped to the fuse, last writes outside the init phase
	task automatic t_scale;
		ahb(1, 8'h08, svw(6'h05, 6'h3A, 1'b1));
		ahb(0, 8'h08, 32'h0);
		chk(q, 32'h00003A05);
		chk({scaling_offset_polarity, scaling_offset_code}, 32'h05);
		ahb(1, 8'h08, svw(6'h03, 6'h00, 1'b0));
		ahb(0, 8'h08, 32'h0);
		chk(q, 32'h01003A05);
		scaling_bidirectional_fuse <= 1'b1;
		ahb(1, 8'h08, svw(6'h3F, 6'h00, 1'b1));
		ahb(0, 8'h08, 32'h0);
		chk(q, 32'h00013807);
		safety_init_phase <= 1'b0;
		ahb(1, 8'h08, svw(6'h01, 6'h3E, 1'b0));
		ahb(1, 8'h00, 32'h0);
		ahb(0, 8'h08, 32'h0);
		chk(q, 32'h00013807);
		ahb(0, 8'h00, 32'h0);
		chk(q, 32'h666);
		safety_init_phase <= 1'b1;
	endtask
	task automatic t_thr;
		for (int i = 0; i < 4; i++) begin
			core_over_threshold_fuse <= 4'(i * 5);
			core_under_threshold_fuse <= 4'(15 - i * 5);
			io_over_threshold_fuse <= 4'(15 - i * 5);
			io_under_threshold_fuse <= 4'(i * 5);
			hv_linear_over_threshold_fuse <= 4'(i * 5);
			hv_linear_under_threshold_fuse <= 4'(15 - i * 5);
			io_nominal_level_fuse <= i[0];
			hv_linear_mode_fuse <= i[1];
			hv_linear_level_fuse <= i[0];
			cyc(2);
			chk(core_over_threshold, 25 + 25 * i);
			chk(core_under_threshold, 100 - 25 * i);
			chk(io_over_threshold, 100 - 25 * i);
			chk(io_under_threshold, 25 + 25 * i);
			chk(hv_linear_over_threshold, 25 + 25 * i);
			chk(hv_linear_under_threshold, 100 - 25 * i);
			chk(io_ref_3v3, i[0]);
			chk({hv_linear_ref_tracks_dac, hv_linear_ref_3v3}, {!i[1], i[1] & i[0]});
		end
	endtask
	task automatic t_core;
		safety_monitor_enable <= 1'b1;
		seen = 0;
		ov_req <= 7'h01;
		cyc(OV - 2);
		chk({failsafe_output_n, reset_output_n}, 3);
		repeat (14) begin
			@(posedge hclk);
			seen |= regulator_off[4];
		end
		chk(seen, 1);
		chk(regulator_off, 0);
		chk({failsafe_output_n, reset_output_n}, 0);
		ov_req <= 0;
		ahb(0, 8'h0C, 32'h0);
		chk(q, 32'h1);
		ahb(1, 8'h0C, 32'h7F7F);
		cyc(4);
		chk({failsafe_output_n, reset_output_n}, 3);
		uv_req <= 7'h01;
		cyc(UV - 2);
		chk({failsafe_output_n, reset_output_n}, 3);
		cyc(12);
		chk({failsafe_output_n, reset_output_n}, 1);
		uv_req <= 0;
		ahb(0, 8'h0C, 32'h0);
		chk(q, 32'h100);
		ahb(1, 8'h0C, 32'h7F7F);
		ahb(1, 8'h00, 32'h664);
		ov_req <= 7'h01;
		cyc(OV + 12);
		chk({failsafe_output_n, reset_output_n}, 3);
		ov_req <= 0;
		ahb(0, 8'h0C, 32'h0);
		chk(q, 32'h1);
		ahb(1, 8'h0C, 32'h7F7F);
		chk(pulses, 2);
	endtask
	task automatic t_io;
		for (int i = 0; i < 2; i++) begin
			io_source_select_fuse <= i ? 3'h2 : 3'h7;
			seen = 0;
			ov_req <= 7'h02;
			repeat (OV + 12) begin
				@(posedge hclk);
				seen |= |regulator_off;
			end
			chk(seen, i);
			ahb(0, 8'h0C, 32'h0);
			chk(q, 32'h2);
			ov_req <= 0;
			cyc(2);
			ahb(1, 8'h0C, 32'h7F7F);
		end
	endtask
	// monitors disabled, so filters stay clear and a long fault leaves no trace
	task automatic t_quiet;
		safety_monitor_enable <= 1'b0;
		uv_req <= 7'h04;
		cyc(700);
		ahb(0, 8'h0C, 32'h0);
		chk(q, 32'h0);
		chk({failsafe_output_n, reset_output_n}, 3);
		uv_req <= 0;
		chk(pulses, 5);
	endtask
	// aux 0 on regulator 3, short over filter; rail has no collapse model
	task automatic t_aux;
		ahb(1, 8'h10, 32'h3);
		ahb(0, 8'h10, 32'h0);
		chk(q, 32'h3);
		ov_req <= 7'h08;
		cyc(3124);
		chk(regulator_off, 0);
		cyc(6);
		chk(regulator_off, 32'h8);
		chk({failsafe_output_n, reset_output_n}, 0);
		ov_req <= 0;
		cyc(4);
		chk(regulator_off, 0);
		ahb(0, 8'h0C, 32'h0);
		chk(q, 32'h8);
		ahb(1, 8'h0C, 32'h7F7F);
	endtask

	initial begin
		cyc(10);
		hresetn <= 1'b1;
		t_regs;
		t_scale;
		t_thr;
		t_core;
		t_io;
		t_aux;
		t_quiet;
		print_verdict;
	end
	initial begin
		cyc(20000);
		n_mismatch++;
		print_verdict;
	end
endmodule
